/* hw/cc_channel_regs.svh */
// Purpose: channel register offsets, fields and reset values
// Assumes: included by bare name from the design files
// Notes:   definitions only
`ifndef CC_CHANNEL_REGS_SVH
`define CC_CHANNEL_REGS_SVH

// Byte offsets on the register bus
`define CC_OFF_CONTROL     8'h00
`define CC_OFF_VALUE_LOW   8'h04
`define CC_OFF_VALUE_HIGH  8'h08
`define CC_OFF_PENDING     8'h0C
`define CC_OFF_ENABLE      8'h10
`define CC_OFF_PRIORITY    8'h14
`define CC_OFF_TIMER_SEL   8'h18
`define CC_OFF_OPEN_DRAIN  8'h1C

// Field positions
`define CC_CTRL_MODE_LSB   0
`define CC_CTRL_DUTY_LSB   4
`define CC_CTRL_MASK       8'h3F
`define CC_FLAG_BIT        1
`define CC_TSEL_MASK       8'h0F
`define CC_OD_BIT          0

// Reset values
`define CC_RST_BYTE        8'h00

// Prescaler terminal counts
`define CC_PRESC_4_LAST    4'h3
`define CC_PRESC_16_LAST   4'hF

// Bus answers
`define CC_RESP_OKAY       2'b00
`define CC_RESP_DECERR     2'b11

`endif

/* hw/cc_channel_pkg.sv */
// Purpose: types shared by the capture/compare channel modules
// Assumes: mode codes follow the 4-bit channel mode field
// Notes:   codes 1101..1111 also select PWM and are decoded by range
package cc_channel_pkg;

   typedef enum logic [3:0] {
      MODE_OFF        = 4'h0,
      MODE_CMP_TOGGLE = 4'h2,
      MODE_CAP_FALL   = 4'h4,
      MODE_CAP_RISE   = 4'h5,
      MODE_CAP_RISE4  = 4'h6,
      MODE_CAP_RISE16 = 4'h7,
      MODE_CMP_HIGH   = 4'h8,
      MODE_CMP_LOW    = 4'h9,
      MODE_CMP_SWINT  = 4'hA,
      MODE_CMP_TRIG   = 4'hB,
      MODE_PWM        = 4'hC
   } mode_t;

   typedef enum logic [1:0] {
      EDGE_FALL   = 2'b00,
      EDGE_RISE   = 2'b01,
      EDGE_RISE4  = 2'b10,
      EDGE_RISE16 = 2'b11
   } edge_sel_t;

   typedef enum logic [2:0] {
      REG_CONTROL,
      REG_VALUE_LOW,
      REG_VALUE_HIGH,
      REG_PENDING,
      REG_ENABLE,
      REG_PRIORITY,
      REG_TIMER_SEL,
      REG_OPEN_DRAIN
   } reg_idx_t;

endpackage

/* hw/cc_link_if.sv */
// Purpose: core to capture and PWM unit signals
// Assumes: one instance per channel, single clock
// Notes:   core drives controls, units return events and levels
`timescale 1ns/1ps
interface cc_link_if;
   import cc_channel_pkg::*;

   logic        capture_en;
   edge_sel_t   edge_sel;
   logic        capture_evt;
   logic        pwm_en;
   logic [9:0]  duty;
   logic        period_match;
   logic [9:0]  timer_fine;
   logic        pwm_out;
   logic [9:0]  duty_held;

   modport core (
      output capture_en,
      output edge_sel,
      input  capture_evt,
      output pwm_en,
      output duty,
      output period_match,
      output timer_fine,
      input  pwm_out,
      input  duty_held
   );

   modport capture (
      input  capture_en,
      input  edge_sel,
      output capture_evt
   );

   modport pwm (
      input  pwm_en,
      input  duty,
      input  period_match,
      input  timer_fine,
      output pwm_out,
      output duty_held
   );
endinterface

/* hw/cc_edge_prescaler.sv */
// Purpose: pin synchroniser, edge detector and capture edge prescaler
// Assumes: pin_in may be asynchronous to aclk
// Notes:   count kept across prescaler switches
`timescale 1ns/1ps
module cc_edge_prescaler
   import cc_channel_pkg::*;
(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       pin_in,
   cc_link_if.capture      link
);
`include "cc_channel_regs.svh"

   logic       sync1_q;
   logic       sync2_q;
   logic       prev_q;
   logic [3:0] count_q;
   logic       evt_q;
   logic       rise;
   logic       fall;

   // Two-stage synchroniser and history flop
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         prev_q  <= 1'b0;
      end else begin
         sync1_q <= pin_in;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end

   assign rise = sync2_q & ~prev_q;
   assign fall = ~sync2_q & prev_q;

   // Prescaler count and capture event
   always_ff @(posedge aclk) begin
      if (!aresetn || !link.capture_en) begin
         count_q <= 4'h0;
         evt_q   <= 1'b0;
      end else begin
         evt_q <= 1'b0;
         unique case (link.edge_sel)
            EDGE_FALL:   evt_q <= fall;
            EDGE_RISE:   evt_q <= rise;
            // Leftover count may fire early
            EDGE_RISE4: begin
               if (rise) begin
                  if (count_q >= `CC_PRESC_4_LAST) begin
                     count_q <= 4'h0;
                     evt_q   <= 1'b1;
                  end else begin
                     count_q <= count_q + 4'h1;
                  end
               end
            end
            EDGE_RISE16: begin
               if (rise) begin
                  if (count_q == `CC_PRESC_16_LAST) begin
                     count_q <= 4'h0;
                     evt_q   <= 1'b1;
                  end else begin
                     count_q <= count_q + 4'h1;
                  end
               end
            end
         endcase
      end
   end

   assign link.capture_evt = evt_q;

endmodule

/* hw/cc_pwm_unit.sv */
// Purpose: 10-bit duty PWM with double-buffered duty value
// Assumes: period_match pulses once per period from the selected timer
// Notes:   duty above the period never clears the output
`timescale 1ns/1ps
module cc_pwm_unit
   import cc_channel_pkg::*;
(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   cc_link_if.pwm          link
);

   logic       out_q;
   logic [9:0] held_q;

   // Duty latched at period end, glitch-free
   always_ff @(posedge aclk) begin
      if (!aresetn || !link.pwm_en) begin
         out_q  <= 1'b0;
         held_q <= 10'h000;
      end else if (link.period_match) begin
         held_q <= link.duty;
         out_q  <= (link.duty != 10'h000);
      end else if (held_q == link.timer_fine) begin
         out_q  <= 1'b0;
      end
   end

   assign link.pwm_out   = out_q;
   assign link.duty_held = held_q;

endmodule

/* hw/cc_channel.sv */
// Purpose: one capture/compare/PWM channel with an AXI4-Lite register slave
// Assumes: timers, port latch and direction bit are outside
// Notes:   registers are 8 bits wide in the low byte lane of each word
// Function
// - open-drain allowed in output modes
// - own select bit turns on open-drain
// - capture copies 16-bit timer count
// - falling, rising, 4th or 16th edge
// - capture sets flag, software clears
// - new capture overwrites old value
// - port write on output pin captures
// - mode change may raise false flag
// - prescaler cleared when off or reset
// - prescaler switch keeps count
// - compare value to timer for equality
// - match sets, clears, toggles or keeps pin
// - flag set with the pin action
// - zero control write clears compare latch
// - mode 1010 match only sets flag
// - mode 1011 match pulses trigger
// - trigger resets the assigned timer
// - trigger never starts a conversion
// - PWM duty has 10-bit resolution
// - select register picks timers per mode
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module cc_channel
   import cc_channel_pkg::*;
#(
   parameter int TIMER_W = 16
)(
   input  wire logic               aclk,
   input  wire logic               aresetn,
   input  wire logic [7:0]         s_axi_awaddr,
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   input  wire logic [7:0]         s_axi_araddr,
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready,
   input  wire logic [TIMER_W-1:0] timer_one_count,
   input  wire logic [TIMER_W-1:0] timer_three_count,
   input  wire logic [7:0]         pwm_timer_count,
   input  wire logic [1:0]         pwm_timer_fine,
   input  wire logic               pwm_period_match,
   input  wire logic               port_direction_bit,
   input  wire logic               port_data_latch,
   input  wire logic               pin_in,
   output logic                    pin_out,
   output logic                    pin_oe,
   output logic                    special_trigger,
   output logic                    timer_one_reset,
   output logic                    timer_three_reset,
   output logic [1:0]              pwm_timer_select,
   output logic                    channel_irq_request,
   output logic                    channel_irq_priority
);
`include "cc_channel_regs.svh"

   // Refuse other timer widths
   if (TIMER_W != 16) begin : g_bad_width
      $error("cc_channel: TIMER_W must be 16");
   end

   // Offset to register index for both decodes
   function automatic logic [3:0] reg_decode(input logic [7:0] addr);
      logic [3:0] idx;
      idx = 4'h8;
      unique case (addr)
         `CC_OFF_CONTROL:    idx = {1'b0, REG_CONTROL};
         `CC_OFF_VALUE_LOW:  idx = {1'b0, REG_VALUE_LOW};
         `CC_OFF_VALUE_HIGH: idx = {1'b0, REG_VALUE_HIGH};
         `CC_OFF_PENDING:    idx = {1'b0, REG_PENDING};
         `CC_OFF_ENABLE:     idx = {1'b0, REG_ENABLE};
         `CC_OFF_PRIORITY:   idx = {1'b0, REG_PRIORITY};
         `CC_OFF_TIMER_SEL:  idx = {1'b0, REG_TIMER_SEL};
         `CC_OFF_OPEN_DRAIN: idx = {1'b0, REG_OPEN_DRAIN};
         default:            idx = 4'h8;
      endcase
      return idx;
   endfunction

   // Mode class decoders
   function automatic logic is_capture(input logic [3:0] m);
      return m[3:2] == 2'b01;
   endfunction

   function automatic logic is_compare(input logic [3:0] m);
      return (m[3:2] == 2'b10) || (m == MODE_CMP_TOGGLE);
   endfunction

   function automatic logic is_pwm(input logic [3:0] m);
      return m[3:2] == 2'b11;
   endfunction

   cc_link_if link ();

   logic [TIMER_W-1:0] cc_timer;

   logic [7:0]  control_q;
   logic [7:0]  value_low_q;
   logic [7:0]  value_high_q;
   logic        flag_q;
   logic        enable_q;
   logic        priority_q;
   logic [3:0]  tsel_q;
   logic        od_q;
   logic        cmp_latch_q;
   logic        eq_q;
   logic        trig_q;
   logic        t1_rst_q;
   logic        t3_rst_q;
   logic        irq_q;
   logic        pin_out_q;
   logic        pin_oe_q;
   logic        aw_hold_q;
   logic        w_hold_q;
   logic [7:0]  awaddr_q;
   logic [7:0]  wbyte_q;
   logic        wlane_q;
   logic        bvalid_q;
   logic [1:0]  bresp_q;
   logic        rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;
   logic [3:0]  mode;
   logic [3:0]  wr_idx;
   logic        do_write;
   logic        wr_en;
   logic        use_timer_three;
   logic        cmp_eq;
   logic        match;
   logic        drive_level;
   logic        od_active;
   logic        want_output;

   assign mode     = control_q[`CC_CTRL_MODE_LSB +: 4];
   assign wr_idx   = reg_decode(awaddr_q);
   assign do_write = aw_hold_q & w_hold_q & ~bvalid_q;
   assign wr_en    = do_write & wlane_q;

   // Write: address and data taken apart, answered together
   assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
   assign s_axi_wready  = ~w_hold_q & ~bvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
         awaddr_q  <= 8'h00;
         wbyte_q   <= 8'h00;
         wlane_q   <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `CC_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            wbyte_q  <= s_axi_wdata[7:0];
            wlane_q  <= s_axi_wstrb[0];
         end
         if (do_write) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_idx[3] ? `CC_RESP_DECERR : `CC_RESP_OKAY;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // Read: one at a time, data from a register
   assign s_axi_arready = ~rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= `CC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q <= 1'b1;
         rresp_q  <= `CC_RESP_OKAY;
         rdata_q  <= 32'h0000_0000;
         unique case (reg_decode(s_axi_araddr))
            {1'b0, REG_CONTROL}:    rdata_q[7:0] <= control_q;
            {1'b0, REG_VALUE_LOW}:  rdata_q[7:0] <= value_low_q;
            // In PWM the high byte shows the latched duty
            {1'b0, REG_VALUE_HIGH}: rdata_q[7:0] <= is_pwm(mode) ?
                                                    link.duty_held[9:2] : value_high_q;
            {1'b0, REG_PENDING}:    rdata_q[`CC_FLAG_BIT] <= flag_q;
            {1'b0, REG_ENABLE}:     rdata_q[`CC_FLAG_BIT] <= enable_q;
            {1'b0, REG_PRIORITY}:   rdata_q[`CC_FLAG_BIT] <= priority_q;
            {1'b0, REG_TIMER_SEL}:  rdata_q[3:0] <= tsel_q;
            {1'b0, REG_OPEN_DRAIN}: rdata_q[`CC_OD_BIT] <= od_q;
            default:                rresp_q <= `CC_RESP_DECERR;
         endcase
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // Configuration registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         control_q  <= `CC_RST_BYTE;
         enable_q   <= 1'b0;
         priority_q <= 1'b0;
         tsel_q     <= 4'h0;
         od_q       <= 1'b0;
      end else if (wr_en) begin
         unique case (wr_idx)
            {1'b0, REG_CONTROL}:    control_q  <= wbyte_q & `CC_CTRL_MASK;
            {1'b0, REG_ENABLE}:     enable_q   <= wbyte_q[`CC_FLAG_BIT];
            {1'b0, REG_PRIORITY}:   priority_q <= wbyte_q[`CC_FLAG_BIT];
            {1'b0, REG_TIMER_SEL}:  tsel_q     <= wbyte_q[3:0];
            {1'b0, REG_OPEN_DRAIN}: od_q       <= wbyte_q[`CC_OD_BIT];
            default: ;
         endcase
      end
   end

   // Codes 01/10/11 pick timer three for capture/compare
   assign use_timer_three = tsel_q[1:0] != 2'b00;
   assign cc_timer        = use_timer_three ? timer_three_count : timer_one_count;
   assign pwm_timer_select = tsel_q[3:2];

   // Capture and PWM unit controls
   assign link.capture_en   = is_capture(mode);
   assign link.edge_sel     = edge_sel_t'(mode[1:0]);
   assign link.pwm_en       = is_pwm(mode);
   assign link.duty         = {value_low_q, control_q[`CC_CTRL_DUTY_LSB +: 2]};
   assign link.period_match = pwm_period_match;
   assign link.timer_fine   = {pwm_timer_count, pwm_timer_fine};

   cc_edge_prescaler u_capture (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin_in  (pin_in),
      .link    (link)
   );

   cc_pwm_unit u_pwm (
      .aclk    (aclk),
      .aresetn (aresetn),
      .link    (link)
   );

   // Value pair: capture beats a same-cycle write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         value_low_q  <= `CC_RST_BYTE;
         value_high_q <= `CC_RST_BYTE;
      end else if (link.capture_evt) begin
         value_low_q  <= cc_timer[7:0];
         value_high_q <= cc_timer[15:8];
      end else if (wr_en) begin
         if (wr_idx == {1'b0, REG_VALUE_LOW}) begin
            value_low_q <= wbyte_q;
         end
         // High byte is read-only while in PWM
         if (wr_idx == {1'b0, REG_VALUE_HIGH} && !is_pwm(mode)) begin
            value_high_q <= wbyte_q;
         end
      end
   end

   // Match on rising edge of equality
   assign cmp_eq = is_compare(mode) && ({value_high_q, value_low_q} == cc_timer);
   assign match  = cmp_eq & ~eq_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         eq_q <= 1'b0;
      end else begin
         eq_q <= cmp_eq;
      end
   end

   // Compare latch; zero control write clears it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmp_latch_q <= 1'b0;
      end else if (wr_en && wr_idx == {1'b0, REG_CONTROL} && wbyte_q == 8'h00) begin
         cmp_latch_q <= 1'b0;
      end else if (match) begin
         unique case (mode)
            MODE_CMP_HIGH:   cmp_latch_q <= 1'b1;
            MODE_CMP_LOW:    cmp_latch_q <= 1'b0;
            MODE_CMP_TOGGLE: cmp_latch_q <= ~cmp_latch_q;
            default:         cmp_latch_q <= cmp_latch_q;
         endcase
      end
   end

   // Flag: hardware set beats software write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_q <= 1'b0;
      end else if (link.capture_evt || match) begin
         flag_q <= 1'b1;
      end else if (wr_en && wr_idx == {1'b0, REG_PENDING}) begin
         flag_q <= wbyte_q[`CC_FLAG_BIT];
      end
   end

   // Trigger and timer resets; no converter start
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trig_q   <= 1'b0;
         t1_rst_q <= 1'b0;
         t3_rst_q <= 1'b0;
      end else begin
         trig_q   <= match && mode == MODE_CMP_TRIG;
         t1_rst_q <= match && mode == MODE_CMP_TRIG && !use_timer_three;
         t3_rst_q <= match && mode == MODE_CMP_TRIG && use_timer_three;
      end
   end

   assign special_trigger   = trig_q;
   assign timer_one_reset   = t1_rst_q;
   assign timer_three_reset = t3_rst_q;

   // Pin level: compare latch, PWM or port latch
   always_comb begin
      drive_level = port_data_latch;
      if (is_pwm(mode)) begin
         drive_level = link.pwm_out;
      end else if (mode == MODE_CMP_HIGH || mode == MODE_CMP_LOW ||
                   mode == MODE_CMP_TOGGLE) begin
         drive_level = cmp_latch_q;
      end
   end

   // Open-drain only in output modes; it never drives high
   assign od_active   = od_q && (is_compare(mode) || is_pwm(mode));
   assign want_output = ~port_direction_bit;

   // Driven pin loops back to pin_in, so a port write can capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_out_q <= 1'b0;
         pin_oe_q  <= 1'b0;
         irq_q     <= 1'b0;
      end else begin
         pin_out_q <= od_active ? 1'b0 : drive_level;
         pin_oe_q  <= want_output && (!od_active || !drive_level);
         irq_q     <= flag_q & enable_q;
      end
   end

   assign pin_out              = pin_out_q;
   assign pin_oe               = pin_oe_q;
   assign channel_irq_request  = irq_q;
   assign channel_irq_priority = priority_q;

endmodule

/* test/cc_env_model.sv */
// Purpose: timer pair and pin line around the channel
// Assumes: timers run on aclk, load and run come from the bench
// Notes:   released line shows the outside level
`timescale 1ns/1ps
module cc_env_model (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        run,
   input  wire logic        ld,
   input  wire logic [15:0] ld_val,
   input  wire logic        ext_level,
   input  wire logic        timer_one_reset,
   input  wire logic        timer_three_reset,
   input  wire logic        pin_out,
   input  wire logic        pin_oe,
   output logic [15:0]      timer_one_count,
   output logic [15:0]      timer_three_count,
   output logic             pin_in
);
   // Counter, cleared by the trigger
   always_ff @(posedge aclk) begin
      if (!aresetn || timer_one_reset) timer_one_count <= 16'h0000;
      else if (ld) timer_one_count <= ld_val;
      else if (run) timer_one_count <= timer_one_count + 16'h0001;
   end
   // Loads the complement to expose a wrong select
   always_ff @(posedge aclk) begin
      if (!aresetn || timer_three_reset) timer_three_count <= 16'h0000;
      else if (ld) timer_three_count <= ~ld_val;
      else if (run) timer_three_count <= timer_three_count + 16'h0001;
   end
   // Driven level feeds back into capture
   assign pin_in = pin_oe ? pin_out : ext_level;
endmodule

/* test/cc_channel_asserts.sv */
// Purpose: port-level properties of the channel
// Assumes: single clock, synchronous active-low reset
// Notes:   bound into every channel instance
`timescale 1ns/1ps
module cc_channel_asserts (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_arready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        port_data_latch,
   input wire logic        pin_out,
   input wire logic        pin_oe,
   input wire logic        special_trigger,
   input wire logic        timer_one_reset,
   input wire logic        timer_three_reset
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_TRIG_ONE: assert property (special_trigger |=> !special_trigger)
      else $error("long trigger");
   AST_TRIG_RST: assert property (special_trigger |-> timer_one_reset ^ timer_three_reset)
      else $error("no single timer reset");
   AST_RST_CAUSE: assert property ((timer_one_reset | timer_three_reset) |-> special_trigger)
      else $error("stray timer reset");
   AST_TRIG_PIN: assert property (special_trigger && pin_oe |-> pin_out == $past(port_data_latch))
      else $error("trigger moved pin");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("bresp dropped");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("rdata dropped");
   AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("ar taken during answer");
   AST_R_HIGH: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("high rdata bits set");
   // Main scenarios reached
   cover property (special_trigger);
   cover property (s_axi_bvalid && s_axi_bresp == 2'b11);
   cover property ($rose(pin_out));
endmodule
bind cc_channel cc_channel_asserts cc_channel_asserts_inst (.*);

/* test/tb.sv */
// Purpose: register-level channel test
// Assumes: offsets as in the register header
// Notes:   timer frozen while capturing
`timescale 1ns/1ps
module tb;
   import cc_channel_pkg::*;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, pwm_period_match, port_direction_bit, port_data_latch, pin_in;
   logic        pin_out, pin_oe, special_trigger, timer_one_reset, timer_three_reset;
   logic        channel_irq_request, channel_irq_priority, run, ld, ext_level;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, pwm_timer_count;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, pwm_timer_fine, pwm_timer_select;
   logic [15:0] timer_one_count, timer_three_count, ld_val, v;
   logic [33:0] r;
   int          num_errors = 0;
   int          n_checks = 0;
   mode_t       cm[4] = '{MODE_CAP_FALL, MODE_CAP_RISE, MODE_CAP_RISE4, MODE_CAP_RISE16};
   int          ct[4] = '{1, 1, 4, 16};
   mode_t       km[7] = '{MODE_CMP_HIGH, MODE_CMP_LOW, MODE_CMP_TOGGLE, MODE_OFF,
                          MODE_CMP_TOGGLE, MODE_CMP_SWINT, MODE_CMP_TRIG};
   int          ke[7] = '{1, 0, 1, 2, 1, 0, 2};
   cc_channel   cc_channel_inst (.*);
   cc_env_model cc_env_model_inst (.*);
   // 200 MHz
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      if (num_errors == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Expired wait ends the run
   task automatic tmo(input int n);
      if (n >= 50) begin
         chk(34'h1, 34'h0);
         test_done();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      int n;
      @(posedge aclk);
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         n++;
      end while (!s_axi_bvalid && n < 50);
      tmo(n);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, er);
   endtask
   // r = {rresp, rdata}
   task automatic rd(input logic [7:0] a);
      int n;
      @(posedge aclk);
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         n++;
      end while (!s_axi_rvalid && n < 50);
      tmo(n);
      r = {s_axi_rresp, s_axi_rdata};
      s_axi_rready <= 1'b0;
   endtask
   // Covers synchroniser latency
   task automatic pulse;
      ext_level <= 1'b1;
      repeat (6) @(posedge aclk);
      ext_level <= 1'b0;
      repeat (6) @(posedge aclk);
   endtask
   task automatic ldt(input logic [15:0] val, input int cyc);
      ld <= 1'b1;
      ld_val <= val;
      @(posedge aclk);
      ld <= 1'b0;
      if (cyc > 0) begin
         run <= 1'b1;
         repeat (cyc) @(posedge aclk);
         run <= 1'b0;
      end
      repeat (4) @(posedge aclk);
   endtask
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, aresetn} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, pwm_timer_count, pwm_timer_fine} = '0;
      {pwm_period_match, port_data_latch, ext_level, run, ld, ld_val} = '0;
      s_axi_wstrb = 4'hF;
      port_direction_bit = 1'b1;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      for (int a = 0; a < 32; a += 4) begin
         rd(8'(a));
         chk(r, 34'h0);
      end
      rd(8'h20);
      chk(r[33:32], 34'h3);
      wr(8'h20, 8'h55, 2'b11);
      wr(8'h00, 8'hC0, 2'b00);
      rd(8'h00);
      chk(r, 34'h0);
      // Each edge mode from a cleared prescaler
      for (int i = 0; i < 4; i++) begin
         wr(8'h00, 8'h00, 2'b00);
         wr(8'h18, {7'h00, i == 3}, 2'b00);
         wr(8'h00, {4'h0, cm[i]}, 2'b00);
         wr(8'h0C, 8'h00, 2'b00);
         v = 16'(16'h1357 * (i + 1));
         ldt(v, 0);
         repeat (ct[i] - 1) pulse();
         rd(8'h0C);
         chk(r, 34'h0);
         pulse();
         rd(8'h0C);
         chk(r, 34'h2);
         rd(8'h0C);
         chk(r, 34'h2);
         v = (i == 3) ? ~v : v;
         rd(8'h04);
         chk(r, v[7:0]);
         rd(8'h08);
         chk(r, v[15:8]);
      end
      // Compare 0010 against running timer
      wr(8'h18, 8'h00, 2'b00);
      wr(8'h04, 8'h10, 2'b00);
      wr(8'h08, 8'h00, 2'b00);
      port_direction_bit <= 1'b0;
      for (int i = 0; i < 7; i++) begin
         wr(8'h00, {4'h0, km[i]}, 2'b00);
         if (km[i] == MODE_OFF) continue;
         wr(8'h0C, 8'h00, 2'b00);
         ldt(16'h0000, 30);
         rd(8'h0C);
         chk(r, 34'h2);
         if (ke[i] < 2) chk(pin_out, ke[i][0]);
      end
      chk(timer_one_count < 16'h0010, 34'h1);
      // Port write on output pin captures
      wr(8'h00, 8'h00, 2'b00);
      wr(8'h00, {4'h0, MODE_CAP_RISE}, 2'b00);
      wr(8'h0C, 8'h00, 2'b00);
      port_data_latch <= 1'b1;
      repeat (6) @(posedge aclk);
      rd(8'h0C);
      chk(r, 34'h2);
      // Open drain: high released, low driven
      ext_level <= 1'b1;
      wr(8'h1C, 8'h01, 2'b00);
      wr(8'h00, 8'h00, 2'b00);
      wr(8'h00, {4'h0, MODE_CMP_HIGH}, 2'b00);
      ldt(16'h0000, 30);
      chk({pin_oe, pin_in}, 34'h1);
      wr(8'h00, {4'h0, MODE_CMP_LOW}, 2'b00);
      ldt(16'h0000, 30);
      chk({pin_oe, pin_out}, 34'h2);
      wr(8'h10, 8'h02, 2'b00);
      @(posedge aclk);
      chk(channel_irq_request, 34'h1);
      test_done();
   end
endmodule
